//--- sra_map.svh
// Constants for the rate adaptation block
// What this block does
// - 2.5G mode runs byte interface at 312.5 MHz
// - No 250 or 25 Mb/s modes in 2.5G
// - Core ignores speed; slow rates repeat bytes
// - Client holds each byte 10 clocks at 100M
// - Client holds each byte 100 clocks at 10M
// - Client leaves the inter-frame gap to the user stream
// - Receive bytes repeated 10 clocks at 100M
// - Receive bytes repeated 100 clocks at 10M
// - Client samples receive bytes once per period
// - Client gives full bytes unless nibble mode
// - Enable rate 125/312.5, 12.5, 1.25 MHz
// - Nibble mode converts bytes and nibbles
// - Transmit data registered, passed to core
// - Client changes transmit data on enable only
// - Nibble mode at 1G takes full bytes
// - Slow nibble mode assembles low nibbles
// - Start delimiter realigned by one nibble
// - Full speed: one byte per clock
// - Transmit fault carried through to partner
// - Fault with 0F extension, 1F late error
`ifndef SRA_MAP_SVH
`define SRA_MAP_SVH
`define SRA_DIV_100M 7'h0A
`define SRA_DIV_10M 7'h64
`define SRA_SFD 8'hD5
`define SRA_SFD_SPLIT 8'h5D
`define SRA_EXT_CODE 8'h0F
`define SRA_LATE_ERR 8'h1F
`define SRA_FIFO_DEPTH 32
`endif

//--- sra_pkg.sv
// Types for the rate adaptation block
package sra_pkg;
    typedef enum logic [1:0] {
        SRA_SPD_10M,
        SRA_SPD_100M,
        SRA_SPD_1G
    } sra_speed_t;
    typedef struct packed {
        logic [7:0] data;
        logic en;
        logic fault;
    } sra_beat_t;
endpackage

//--- sra_link_if.sv
// Client-side byte link between the adaptation end and the client end
interface sra_link_if;
    logic [7:0] txd;
    logic tx_en;
    logic client_tx_fault;
    logic [7:0] rxd;
    logic rx_dv;
    logic client_rx_fault;
    logic clk_en;
    logic ddr_clk_en;
    modport adapter (input txd, input tx_en, input client_tx_fault,
        output rxd, output rx_dv, output client_rx_fault, output clk_en, output ddr_clk_en);
    modport client (output txd, output tx_en, output client_tx_fault,
        input rxd, input rx_dv, input client_rx_fault, input clk_en, input ddr_clk_en);
endinterface

//--- sra_fifo.sv
// Synchronous valid/ready FIFO
module sra_fifo #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 32
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic clear_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // Handshake terms
    assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_q];

    // Pointer and count update
    always_comb begin
        wr_d = wr_q;
        rd_d = rd_q;
        cnt_d = cnt_q;
        if (clear_i) begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end else begin
            if (push) wr_d = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            if (pop) rd_d = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end

    // Storage array
    always_ff @(posedge clock_i) begin
        if (push && !clear_i) begin
            mem[wr_q] <= in_data_i;
        end
    end
endmodule

//--- sra_adapter.sv
// Rate adaptation end facing the fixed-rate core
`include "sra_map.svh"
module sra_adapter import sra_pkg::*; #(
    parameter int FIFO_DEPTH = `SRA_FIFO_DEPTH
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic sync_reset_i,
    input wire logic [1:0] speed_i,
    input wire logic nibble_mode_i,
    sra_link_if.adapter link,
    output logic [7:0] core_txd_o,
    output logic core_tx_en_o,
    output logic core_tx_fault_o,
    input wire logic [7:0] core_rxd_i,
    input wire logic core_rx_dv_i,
    input wire logic core_rx_fault_i,
    output logic core_rx_ready_o
);
    // Core runs at ref_clock_125 (or 312.5 MHz in 2.5G); no speed awareness there

    // ------------------------------------------------------------
    // Clock enable divider
    // ------------------------------------------------------------
    logic [6:0] div_q, div_d, div_top;
    logic ce, ce_ddr, ddr_q, ddr_d;
    logic slow;
    assign slow = (speed_i < 2'(SRA_SPD_1G)); // Codes 2 and 3 both run full rate
    always_comb begin
        // Divide ratio per speed
        if (speed_i == 2'(SRA_SPD_10M)) div_top = `SRA_DIV_10M;
        else if (speed_i == 2'(SRA_SPD_100M)) div_top = `SRA_DIV_100M;
        else div_top = 7'h01;
        div_d = (div_q >= div_top - 7'h01) ? 7'h00 : div_q + 7'h01;
        ddr_d = ddr_q;
        if (div_q == ((div_top >> 1) - 7'h01)) ddr_d = 1'b1;
        else ddr_d = 1'b0;
        if (sync_reset_i) begin
            div_d = 7'h00;
            ddr_d = 1'b0;
        end
    end
    assign ce = (div_q == 7'h00) && !sync_reset_i;
    assign ce_ddr = ce || ddr_q;
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            div_q <= 7'h00;
            ddr_q <= 1'b0;
        end else begin
            div_q <= div_d;
            ddr_q <= ddr_d;
        end
    end
    assign link.clk_en = ce;
    assign link.ddr_clk_en = ce_ddr;

    // ------------------------------------------------------------
    // Transmit path
    // ------------------------------------------------------------
    logic [7:0] txd_q, txd_d, hold_q, hold_d;
    logic en_q, en_d, flt_q, flt_d, half_q, half_d, aligned_q, aligned_d;
    logic [3:0] nib_q, nib_d;
    logic [7:0] asm_byte, shift_byte;
    assign asm_byte = {link.txd[3:0], nib_q};
    assign shift_byte = {nib_q, hold_q[7:4]};
    always_comb begin
        txd_d = txd_q;
        en_d = en_q;
        flt_d = flt_q;
        hold_d = hold_q;
        nib_d = nib_q;
        half_d = half_q;
        aligned_d = aligned_q;
        if (nibble_mode_i && slow) begin
            // Assemble low nibbles on the double-rate enable
            if (ce_ddr) begin
                if (!link.tx_en) begin
                    half_d = 1'b0;
                    aligned_d = 1'b0;
                    en_d = 1'b0;
                    flt_d = 1'b0;
                end else if (!half_q) begin
                    nib_d = link.txd[3:0];
                    half_d = 1'b1;
                end else begin
                    half_d = 1'b0;
                    hold_d = asm_byte;
                    // Realign a straddling start delimiter
                    if (!aligned_q && shift_byte == `SRA_SFD && asm_byte != `SRA_SFD) begin
                        aligned_d = 1'b1;
                        half_d = 1'b1;
                        nib_d = link.txd[3:0];
                        txd_d = shift_byte;
                    end else begin
                        if (asm_byte == `SRA_SFD) aligned_d = 1'b1;
                        txd_d = asm_byte;
                    end
                    en_d = 1'b1;
                    flt_d = link.client_tx_fault;
                end
            end
        end else begin
            // Full bytes sampled once per enable
            if (ce) begin
                txd_d = link.txd;
                en_d = link.tx_en;
                flt_d = link.client_tx_fault;
            end
        end
        if (sync_reset_i) begin
            txd_d = 8'h00;
            en_d = 1'b0;
            flt_d = 1'b0;
            half_d = 1'b0;
            aligned_d = 1'b0;
            nib_d = 4'h0;
            hold_d = 8'h00;
        end
    end
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            txd_q <= 8'h00;
            en_q <= 1'b0;
            flt_q <= 1'b0;
            hold_q <= 8'h00;
            nib_q <= 4'h0;
            half_q <= 1'b0;
            aligned_q <= 1'b0;
        end else begin
            txd_q <= txd_d;
            en_q <= en_d;
            flt_q <= flt_d;
            hold_q <= hold_d;
            nib_q <= nib_d;
            half_q <= half_d;
            aligned_q <= aligned_d;
        end
    end
    assign core_txd_o = txd_q;
    assign core_tx_en_o = en_q;
    assign core_tx_fault_o = flt_q;

    // ------------------------------------------------------------
    // Receive path: FIFO then repeat each byte for one enable period
    // ------------------------------------------------------------
    sra_beat_t in_beat, out_beat;
    logic out_valid, out_ready;
    assign in_beat = '{data: core_rxd_i, en: core_rx_dv_i, fault: core_rx_fault_i};
    sra_fifo #(.WIDTH($bits(sra_beat_t)), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .clear_i(sync_reset_i),
        .in_data_i(in_beat),
        .in_valid_i(ce), // One sample per period, core repeats slow bytes
        .in_ready_o(core_rx_ready_o),
        .out_data_o(out_beat),
        .out_valid_o(out_valid),
        .out_ready_i(out_ready)
    );
    logic [7:0] rxd_q, rxd_d;
    logic rdv_q, rdv_d, rflt_q, rflt_d, rhi_q, rhi_d;
    logic [3:0] rnib_q, rnib_d;
    assign out_ready = ce;
    always_comb begin
        rxd_d = rxd_q;
        rdv_d = rdv_q;
        rflt_d = rflt_q;
        rhi_d = rhi_q;
        rnib_d = rnib_q;
        // New byte at each enable, held for the whole period
        if (ce) begin
            rxd_d = out_valid ? out_beat.data : 8'h00;
            rdv_d = out_valid && out_beat.en;
            // Extension 0F and late error 1F pass with fault high
            rflt_d = out_valid && out_beat.fault;
            rnib_d = out_valid ? out_beat.data[7:4] : 4'h0;
            rhi_d = 1'b0;
        end else if (ce_ddr) begin
            rhi_d = 1'b1;
        end
        if (sync_reset_i) begin
            rxd_d = 8'h00;
            rdv_d = 1'b0;
            rflt_d = 1'b0;
            rhi_d = 1'b0;
            rnib_d = 4'h0;
        end
    end
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rxd_q <= 8'h00;
            rdv_q <= 1'b0;
            rflt_q <= 1'b0;
            rhi_q <= 1'b0;
            rnib_q <= 4'h0;
        end else begin
            rxd_q <= rxd_d;
            rdv_q <= rdv_d;
            rflt_q <= rflt_d;
            rhi_q <= rhi_d;
            rnib_q <= rnib_d;
        end
    end
    // Nibble mode at 10M/100M sends low nibble then high nibble
    assign link.rxd = (nibble_mode_i && slow) ?
        {4'h0, (rhi_q ? rnib_q : rxd_q[3:0])} : rxd_q;
    assign link.rx_dv = rdv_q;
    assign link.client_rx_fault = rflt_q;
endmodule

//--- sra_client.sv
// Client end driving and sampling the byte link
`include "sra_map.svh"
module sra_client import sra_pkg::*; (
    input wire logic clock_i,
    input wire logic resetn_i,
    sra_link_if.client link,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    input wire logic tx_fault_i,
    output logic tx_ready_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    output logic rx_fault_o
);
    // ------------------------------------------------------------
    // Transmit: change data only on clock enable, hold between
    // ------------------------------------------------------------
    logic [7:0] txd_q, txd_d;
    logic en_q, en_d, flt_q, flt_d;
    assign tx_ready_o = link.clk_en;
    always_comb begin
        txd_d = txd_q;
        en_d = en_q;
        flt_d = flt_q;
        // Held across the whole 1, 10 or 100 cycle period
        if (link.clk_en) begin
            txd_d = tx_valid_i ? tx_data_i : 8'h00;
            en_d = tx_valid_i;
            flt_d = tx_valid_i && tx_fault_i;
        end
    end
    // Gap between frames is left to the user stream
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            txd_q <= 8'h00;
            en_q <= 1'b0;
            flt_q <= 1'b0;
        end else begin
            txd_q <= txd_d;
            en_q <= en_d;
            flt_q <= flt_d;
        end
    end
    assign link.txd = txd_q;
    assign link.tx_en = en_q;
    assign link.client_tx_fault = flt_q;

    // ------------------------------------------------------------
    // Receive: one sample per repetition period
    // ------------------------------------------------------------
    logic [7:0] rxd_q, rxd_d;
    logic rv_q, rv_d, rf_q, rf_d;
    always_comb begin
        rxd_d = rxd_q;
        rv_d = 1'b0;
        rf_d = rf_q;
        if (link.clk_en) begin
            rxd_d = link.rxd;
            rv_d = link.rx_dv;
            rf_d = link.client_rx_fault;
        end
    end
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rxd_q <= 8'h00;
            rv_q <= 1'b0;
            rf_q <= 1'b0;
        end else begin
            rxd_q <= rxd_d;
            rv_q <= rv_d;
            rf_q <= rf_d;
        end
    end
    assign rx_data_o = rxd_q;
    assign rx_valid_o = rv_q;
    assign rx_fault_o = rf_q;
endmodule

//--- sra_link_checker.sv
// Assertions watching the byte link between the adaptation end and the client end
module sra_link_checker (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic sync_reset_i,
    input wire logic [1:0] speed_i,
    input wire logic nibble_mode_i,
    input wire logic [7:0] txd,
    input wire logic tx_en,
    input wire logic client_tx_fault,
    input wire logic [7:0] rxd,
    input wire logic rx_dv,
    input wire logic client_rx_fault,
    input wire logic clk_en,
    input wire logic ddr_clk_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    logic [7:0] gap_q, gap_d;
    logic [1:0] ddr_n_q, ddr_n_d;
    logic started_q, started_d;
    // -----------------------------------------
    // Period counters
    // -----------------------------------------
    // Cycles and half-period pulses since the last enable
    always_comb begin
        gap_d = (gap_q == 8'hFF) ? gap_q : gap_q + 8'h01;
        ddr_n_d = (ddr_n_q == 2'h3) ? ddr_n_q : ddr_n_q + {1'b0, ddr_clk_en};
        started_d = started_q;
        if (clk_en) begin
            gap_d = 8'h01;
            ddr_n_d = 2'h1;
            started_d = 1'b1;
        end
        if (sync_reset_i) begin
            started_d = 1'b0; // Divider restarts, first period unknown
        end
    end
    // Register the counters
    always_ff @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            gap_q <= 8'h00;
            ddr_n_q <= 2'h0;
            started_q <= 1'b0;
        end else begin
            gap_q <= gap_d;
            ddr_n_q <= ddr_n_d;
            started_q <= started_d;
        end
    end
    // -----------------------------------------
    // Assertions
    // -----------------------------------------
    property fast_period_p;
        @(posedge clock_i) disable iff (!resetn_i || sync_reset_i)
        speed_i == 2'h1 && clk_en |=> !clk_en [*8] ##1 !clk_en ##1 clk_en;
    endproperty
    full_rate_enable_a: assert property (speed_i[1] && !sync_reset_i && !$past(sync_reset_i) |-> clk_en)
        else $error("enable missing at full rate");
    fast_period_a: assert property (fast_period_p)
        else $error("enable period wrong at 100M");
    slow_period_a: assert property (speed_i == 2'h0 && clk_en && started_q |-> gap_q == 8'h64)
        else $error("enable period wrong at 10M");
    half_pulse_count_a: assert property (!speed_i[1] && clk_en && started_q |-> ddr_n_q == 2'h2)
        else $error("half-period enable count wrong");
    enable_in_half_a: assert property (clk_en |-> ddr_clk_en)
        else $error("half-period enable misses main enable");
    sync_stops_enable_a: assert property (sync_reset_i |-> !clk_en)
        else $error("enable high during sync reset");
    rx_stands_a: assert property (!nibble_mode_i && !$past(nibble_mode_i) && !$past(clk_en) && !$past(sync_reset_i) |-> $stable(rxd) && $stable(rx_dv) && $stable(client_rx_fault))
        else $error("receive byte changed inside period");
    tx_stands_a: assert property (!$past(clk_en) && !$past(sync_reset_i) |-> $stable(txd) && $stable(tx_en) && $stable(client_tx_fault))
        else $error("transmit byte changed off enable");
    // Main scenarios reached
    cover property (speed_i == 2'h1 && rx_dv && clk_en);
    cover property (client_rx_fault && !rx_dv && rxd == 8'h0F);
    cover property (speed_i == 2'h0 && tx_en && clk_en);
endmodule

//--- tb_top.sv
// Self-checking bench joining the adaptation end and the client end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic sync_reset_i = 1'b0;
    logic [1:0] speed_i = 2'h2;
    logic nibble_mode_i = 1'b0;
    logic [7:0] core_rxd_i = 8'h00;
    logic core_rx_dv_i = 1'b0;
    logic core_rx_fault_i = 1'b0;
    logic [7:0] tx_data_i = 8'h00;
    logic tx_valid_i = 1'b0;
    logic tx_fault_i = 1'b0;
    logic [7:0] core_txd_o, rx_data_o;
    logic core_tx_en_o, core_tx_fault_o, core_rx_ready_o, tx_ready_o, rx_valid_o, rx_fault_o;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    logic ce_q = 1'b0;
    logic [1:0] ext_q = 2'h0;
    logic [8:0] txq [$];
    logic [8:0] rxq [$];
    int tq [$];
    logic [8:0] pat [4] = '{9'h055, 9'h0D5, 9'h1A1, 9'h03C};
    logic [1:0] sps [4] = '{2'h2, 2'h1, 2'h0, 2'h3};
    int pers [4] = '{1, 10, 100, 1};
    sra_link_if lk ();
    sra_adapter #(.FIFO_DEPTH(32)) u_sra_adapter (
        .clock_i(clock_i), .resetn_i(resetn_i), .sync_reset_i(sync_reset_i), .speed_i(speed_i),
        .nibble_mode_i(nibble_mode_i), .link(lk), .core_txd_o(core_txd_o),
        .core_tx_en_o(core_tx_en_o), .core_tx_fault_o(core_tx_fault_o), .core_rxd_i(core_rxd_i),
        .core_rx_dv_i(core_rx_dv_i), .core_rx_fault_i(core_rx_fault_i),
        .core_rx_ready_o(core_rx_ready_o));
    sra_client u_sra_client (
        .clock_i(clock_i), .resetn_i(resetn_i), .link(lk), .tx_data_i(tx_data_i),
        .tx_valid_i(tx_valid_i), .tx_fault_i(tx_fault_i), .tx_ready_o(tx_ready_o),
        .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .rx_fault_o(rx_fault_o));
    sra_link_checker u_sra_link_checker (
        .clock_i(clock_i), .resetn_i(resetn_i), .sync_reset_i(sync_reset_i), .speed_i(speed_i),
        .nibble_mode_i(nibble_mode_i), .txd(lk.txd), .tx_en(lk.tx_en),
        .client_tx_fault(lk.client_tx_fault), .rxd(lk.rxd), .rx_dv(lk.rx_dv),
        .client_rx_fault(lk.client_rx_fault), .clk_en(lk.clk_en), .ddr_clk_en(lk.ddr_clk_en));
    // -----------------------------------------
    // Clock and monitors
    // -----------------------------------------
    always #5 clock_i = ~clock_i;
    // Collect settled values at the falling edge, core bytes once per period
    always @(negedge clock_i) begin
        cyc <= cyc + 1;
        ce_q <= lk.clk_en;
        if (ce_q === 1'b1 && core_tx_en_o === 1'b1) begin
            txq.push_back({core_tx_fault_o, core_txd_o});
            tq.push_back(cyc);
        end
        if (rx_valid_o === 1'b1) rxq.push_back({rx_fault_o, rx_data_o});
        if (lk.client_rx_fault === 1'b1 && lk.rx_dv === 1'b0 && lk.rxd === 8'h0F) ext_q[0] <= 1'b1;
        if (lk.client_rx_fault === 1'b1 && lk.rx_dv === 1'b0 && lk.rxd === 8'h1F) ext_q[1] <= 1'b1;
    end
    // -----------------------------------------
    // Tasks
    // -----------------------------------------
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic timeout();
        fails++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        give_verdict();
    endtask
    // Change speed under a one-cycle sync reset, then core transmit must be idle
    task automatic set_speed(input logic [1:0] sp, input logic nb);
        speed_i <= sp;
        nibble_mode_i <= nb;
        sync_reset_i <= 1'b1;
        @(posedge clock_i);
        sync_reset_i <= 1'b0;
        @(negedge clock_i);
        cmp({14'h0, core_tx_en_o, core_tx_fault_o}, 16'h0);
        @(posedge clock_i);
    endtask
    // Hold one byte until the client takes it
    task automatic send(input logic [8:0] b);
        int k;
        logic r;
        tx_data_i <= b[7:0];
        tx_fault_i <= b[8];
        tx_valid_i <= 1'b1;
        for (k = 0; k < 300; k++) begin
            @(negedge clock_i);
            r = tx_ready_o;
            @(posedge clock_i);
            if (r === 1'b1) break;
        end
        if (k == 300) timeout();
    endtask
    task automatic core_put(input logic [8:0] b, input logic dv);
        core_rxd_i <= b[7:0];
        core_rx_fault_i <= b[8];
        core_rx_dv_i <= dv;
        @(posedge clock_i);
    endtask
    task automatic wait_rxd(input logic [7:0] v);
        int k;
        for (k = 0; k < 60; k++) begin
            @(negedge clock_i);
            if (lk.rxd === v) break;
        end
        if (k == 60) timeout();
        cmp({8'h0, lk.rxd}, {8'h0, v});
    endtask
    // -----------------------------------------
    // Scenarios
    // -----------------------------------------
    initial begin
        int s;
        int i;
        logic full;
        repeat (10) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        // Transmit at every speed, nibble mode on at the last one
        for (s = 0; s < 4; s++) begin
            set_speed(sps[s], s == 3);
            txq.delete();
            tq.delete();
            for (i = 0; i < 4; i++) send(pat[i]);
            tx_valid_i <= 1'b0;
            repeat (pers[s] * 3 + 4) @(posedge clock_i);
            cmp(16'(txq.size()), 16'h4);
            for (i = 1; i < txq.size(); i++) cmp(16'(tq[i] - tq[i - 1]), 16'(pers[s]));
            for (i = 0; i < txq.size() && i < 4; i++) cmp({7'h0, txq[i]}, {7'h0, pat[i]});
        end
        // Sync reset in mid-frame
        set_speed(2'h1, 1'b0);
        send(9'h055);
        send(9'h055);
        set_speed(2'h2, 1'b0);
        tx_valid_i <= 1'b0;
        // Full-rate receive with fault and extension codes
        rxq.delete();
        for (i = 0; i < 4; i++) core_put(pat[i], 1'b1);
        core_put(9'h10F, 1'b0);
        core_put(9'h11F, 1'b0);
        core_put(9'h000, 1'b0);
        repeat (8) @(posedge clock_i);
        for (i = 0; i < 4; i++) cmp({7'h0, rxq[i]}, {7'h0, pat[i]});
        cmp({14'h0, ext_q}, 16'h3);
        // Receive at 100M: core repeats each byte 10 cycles, buffer never refuses
        set_speed(2'h1, 1'b0);
        rxq.delete();
        full = 1'b0;
        for (i = 0; i < 6; i++) begin
            core_put({1'b0, 8'h40 + 8'(i)}, 1'b1);
            repeat (9) @(posedge clock_i);
            if (core_rx_ready_o !== 1'b1) full = 1'b1;
        end
        core_put(9'h000, 1'b0);
        repeat (30) @(posedge clock_i);
        cmp({15'h0, full}, 16'h0);
        for (i = 0; i < 6; i++) cmp({7'h0, rxq[i]}, 16'h40 + 16'(i));
        repeat (400) @(posedge clock_i);
        cmp({15'h0, core_rx_ready_o}, 16'h1);
        // Nibble transmit at 100M: 5/5 pair, then D pair realigned to the delimiter
        set_speed(2'h1, 1'b1);
        txq.delete();
        send(9'h005);
        send(9'h00D);
        tx_valid_i <= 1'b0;
        repeat (25) @(posedge clock_i);
        cmp(16'(txq.size()), 16'h2);
        cmp({7'h0, txq[0]}, 16'h055);
        cmp({7'h0, txq[1]}, 16'h0D5);
        // Nibble receive: low half first, then high
        set_speed(2'h1, 1'b1);
        core_put(9'h0A5, 1'b1);
        repeat (9) @(posedge clock_i);
        core_put(9'h000, 1'b0);
        wait_rxd(8'h05);
        wait_rxd(8'h0A);
        give_verdict();
    end
endmodule
